// ### hdl/clock_divider_consts.vh
// Constants for the half-rate and quarter/sixth-rate clock divider
// Summary of operation
// - Both dividers advance from the same sampled input clock edge, so common edges line up.
// - Ratio select low makes the slow pair divide by four, high makes it divide by six.
// - The active-low enable is captured on the falling edge of the input clock.
// - Dividers start or stop only while the internal clock is low, so no runt pulse appears.
// - With enable low and master reset low the dividers step on each rising edge; enable high holds them.
// - Master reset high forces every divided output to its reset state, whatever clock and enable do.
// - The alignment output is high for one input clock cycle when both divided outputs rise together.
// - One shared phase counter keeps the half-rate and slow-rate outputs aligned from any start state.
// - Inputs left open read low; the true divided outputs then stay low and their complements stay high.
`ifndef CLOCK_DIVIDER_CONSTS_VH
`define CLOCK_DIVIDER_CONSTS_VH

`define RATIO_SLOW_LOW   3'h4
`define RATIO_SLOW_HIGH  3'h6
`define PHASE_CNT_W      3
`define PHASE_CNT_RESET  3'h0
`define PHASE_CNT_FIRST  3'h1
`define TRUE_OUT_RESET   1'b0
`define COMP_OUT_RESET   1'b1
`define ENABLE_N_RESET   1'b1
`define SYNC_STAGES_RST  1'b0
`define PIN_COUNT        4
`define PIN_IDX_CLK      3
`define PIN_IDX_ENABLE_N 2
`define PIN_IDX_MRESET   1
`define PIN_IDX_RATIO    0

`endif

// ### hdl/clock_divider_two_four_six.v
// Half-rate and quarter/sixth-rate divider of a sampled input clock
`timescale 1ns/1ps
`include "clock_divider_consts.vh"

module clock_divider_two_four_six
#(
  parameter CNT_W = `PHASE_CNT_W
)
(
  // System clock and reset
  input  wire clk_sys,
  input  wire resetn,
  // Pins from the clock source and control
  input  wire clk_in,
  input  wire enable_n,
  input  wire master_reset,
  input  wire ratio_select,
  // Half-rate pair
  output wire half_rate_out_a,
  output wire half_rate_out_a_n,
  output wire half_rate_out_b,
  output wire half_rate_out_b_n,
  // Slow-rate pair
  output wire slow_rate_out_a,
  output wire slow_rate_out_a_n,
  output wire slow_rate_out_b,
  output wire slow_rate_out_b_n,
  // Alignment pulse
  output wire phase_out,
  output wire phase_out_n
);

  // Pin edges are seen three clk_sys cycles late; the input clock must
  // keep each level for one cycle at least, or an edge is lost
  wire [`PIN_COUNT-1:0] pins_s;
  wire                  clk_s;
  wire                  enable_n_s;
  wire                  master_reset_s;
  wire                  ratio_select_s;

  // Pins are asynchronous to clk_sys; an open pin reads low here
  pin_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_pin_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_in       ({clk_in, enable_n, master_reset, ratio_select}),
    .pin_sync_out (pins_s)
  );

  assign clk_s          = pins_s[`PIN_IDX_CLK];
  assign enable_n_s     = pins_s[`PIN_IDX_ENABLE_N];
  assign master_reset_s = pins_s[`PIN_IDX_MRESET];
  assign ratio_select_s = pins_s[`PIN_IDX_RATIO];

  reg             clk_prev_ff;
  reg             en_n_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg             half_ff;
  reg             half_n_ff;
  reg             slow_ff;
  reg             slow_n_ff;
  reg             phase_ff;
  reg             phase_n_ff;
  // One flop per output pin, so each pin leaves its own flop
  reg             half_b_ff;
  reg             half_b_n_ff;
  reg             slow_b_ff;
  reg             slow_b_n_ff;

  wire clk_rise;
  wire clk_fall;
  assign clk_rise = clk_s & ~clk_prev_ff;
  assign clk_fall = ~clk_s & clk_prev_ff;

  // Previous level of the synchronised clock, for edge detection
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      clk_prev_ff <= `SYNC_STAGES_RST;
    end
    else
    begin
      clk_prev_ff <= clk_s;
    end
  end

  // Enable flop moves only on the falling edge, while the input clock is low,
  // so a start or stop can never chop a divided high phase short
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      en_n_ff <= `ENABLE_N_RESET;
    end
    else if (clk_fall)
    begin
      en_n_ff <= enable_n_s;
    end
  end

  reg [CNT_W-1:0] ratio;
  reg [CNT_W-1:0] half_ratio;
  reg [CNT_W-1:0] nxt_cnt;
  reg             nxt_half;
  reg             nxt_slow;
  reg             step;
  reg             nxt_phase;

  always @*
  begin
    ratio      = ratio_select_s ? `RATIO_SLOW_HIGH : `RATIO_SLOW_LOW;
    half_ratio = ratio >> 1;
    step       = clk_rise & ~en_n_ff;
    nxt_cnt    = cnt_ff;
    if (step)
    begin
      // Wrap keeps strict parity alternation, even from a stray count
      // left by a ratio change or a random start
      if (cnt_ff >= ratio - `PHASE_CNT_FIRST)
      begin
        nxt_cnt = cnt_ff[0] ? `PHASE_CNT_RESET : `PHASE_CNT_FIRST;
      end
      else
      begin
        nxt_cnt = cnt_ff + `PHASE_CNT_FIRST;
      end
    end
    // One counter drives both outputs, so shared edges fall together
    nxt_half = nxt_cnt[0];
    nxt_slow = (nxt_cnt >= `PHASE_CNT_FIRST) && (nxt_cnt <= half_ratio);
    // A ratio change may move the slow pair at once; change it only
    // under master reset when clean slow edges matter; a hold still re-decodes it
    // Pulse only where both pairs rise on the same step
    nxt_phase = step & nxt_half & ~half_ff & nxt_slow & ~slow_ff;
  end

  // Counter and all pairs clear together, so a master reset leaves
  // every divider on a board at the same phase
  always @(posedge clk_sys)
  begin
    if (!resetn || master_reset_s)
    begin
      cnt_ff <= `PHASE_CNT_RESET;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Half-rate pair
  always @(posedge clk_sys)
  begin
    if (!resetn || master_reset_s)
    begin
      half_ff     <= `TRUE_OUT_RESET;
      half_n_ff   <= `COMP_OUT_RESET;
      half_b_ff   <= `TRUE_OUT_RESET;
      half_b_n_ff <= `COMP_OUT_RESET;
    end
    else
    begin
      half_ff     <= nxt_half;
      half_n_ff   <= ~nxt_half;
      half_b_ff   <= nxt_half;
      half_b_n_ff <= ~nxt_half;
    end
  end

  // Slow-rate pair, stepped by the same counter as the half pair
  always @(posedge clk_sys)
  begin
    if (!resetn || master_reset_s)
    begin
      slow_ff     <= `TRUE_OUT_RESET;
      slow_n_ff   <= `COMP_OUT_RESET;
      slow_b_ff   <= `TRUE_OUT_RESET;
      slow_b_n_ff <= `COMP_OUT_RESET;
    end
    else
    begin
      slow_ff     <= nxt_slow;
      slow_n_ff   <= ~nxt_slow;
      slow_b_ff   <= nxt_slow;
      slow_b_n_ff <= ~nxt_slow;
    end
  end

  // Pulse spans one input period: set and cleared on rising input edges;
  // a held divider still clears it, so it never stretches over a hold
  always @(posedge clk_sys)
  begin
    if (!resetn || master_reset_s)
    begin
      phase_ff   <= `TRUE_OUT_RESET;
      phase_n_ff <= `COMP_OUT_RESET;
    end
    else if (clk_rise)
    begin
      phase_ff   <= nxt_phase;
      phase_n_ff <= ~nxt_phase;
    end
  end

  // Outputs leave straight from their flops
  assign half_rate_out_a   = half_ff;
  assign half_rate_out_a_n = half_n_ff;
  assign half_rate_out_b   = half_b_ff;
  assign half_rate_out_b_n = half_b_n_ff;
  assign slow_rate_out_a   = slow_ff;
  assign slow_rate_out_a_n = slow_n_ff;
  assign slow_rate_out_b   = slow_b_ff;
  assign slow_rate_out_b_n = slow_b_n_ff;
  assign phase_out         = phase_ff;
  assign phase_out_n       = phase_n_ff;

endmodule

// ### hdl/pin_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`include "clock_divider_consts.vh"

module pin_sync
#(
  parameter WIDTH = 4
)
(
  // Clock and reset
  input  wire             clk_sys,
  input  wire             resetn,
  // Pins and synchronised copies
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // First stage feeds only the second stage
      always @(posedge clk_sys)
      begin
        if (!resetn)
        begin
          meta_ff[i] <= `SYNC_STAGES_RST;
          sync_ff[i] <= `SYNC_STAGES_RST;
        end
        else
        begin
          meta_ff[i] <= pin_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign pin_sync_out = sync_ff;

endmodule

// ### test/clk_in_source.sv
// Free-running input clock source stepped off the system clock
`timescale 1ns/1ps
module clk_in_source
#(
  parameter HALF = 4
)
(
  // Clocks
  input  wire logic clk_sys,
  output logic      clk_in
);
  int cnt = 0;
  initial clk_in = 1'b0;
  // Levels of HALF cycles keep it slow enough to be sampled
  always @(posedge clk_sys)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      clk_in <= ~clk_in;
  end
endmodule

// ### test/divider_properties.sv
// Port checks for the divider
`timescale 1ns/1ps
module divider_checker
(
  // Clock, reset, pins
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_in,
  input wire logic master_reset,
  input wire logic ratio_select,
  // Outputs
  input wire logic half_rate_out_a,
  input wire logic half_rate_out_a_n,
  input wire logic half_rate_out_b,
  input wire logic half_rate_out_b_n,
  input wire logic slow_rate_out_a,
  input wire logic slow_rate_out_a_n,
  input wire logic slow_rate_out_b,
  input wire logic slow_rate_out_b_n,
  input wire logic phase_out,
  input wire logic phase_out_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence mr_held;
    master_reset [*4];
  endsequence
  sequence in_idle;
    (!clk_in && !master_reset) [*4];
  endsequence
  AST_COMP: assert property (half_rate_out_a_n == !half_rate_out_a &&
    slow_rate_out_a_n == !slow_rate_out_a && phase_out_n == !phase_out &&
    half_rate_out_b_n == !half_rate_out_b && slow_rate_out_b_n == !slow_rate_out_b)
    else $error("complement");
  AST_PAIR: assert property ({half_rate_out_b, slow_rate_out_b} ==
    {half_rate_out_a, slow_rate_out_a}) else $error("pair differs");
  AST_RST: assert property (disable iff (1'b0) !resetn |=>
    !half_rate_out_a && !slow_rate_out_a && !phase_out) else $error("reset level");
  AST_MR: assert property (mr_held |=>
    !half_rate_out_a && !slow_rate_out_a && !phase_out) else $error("master reset");
  AST_HOLD: assert property (in_idle |=>
    $stable({half_rate_out_a, slow_rate_out_a, phase_out})) else $error("moved");
  AST_PHASE: assert property ($rose(phase_out) == $rose(slow_rate_out_a))
    else $error("phase pulse");
  AST_ALIGN: assert property ($rose(slow_rate_out_a) |-> $rose(half_rate_out_a))
    else $error("edges apart");
  AST_RATIO: assert property ($fell(slow_rate_out_a) && !master_reset &&
    ratio_select == $past(ratio_select, 8) |-> $rose(half_rate_out_a) == !ratio_select)
    else $error("ratio");
endmodule
bind clock_divider_two_four_six divider_checker chk_i (.*);

// ### test/tb_clock_divider_two_four_six.sv
// Self-checking bench for the divider
`timescale 1ns/1ps
module tb_clock_divider_two_four_six;
  logic clk_sys, resetn, clk_in, enable_n, master_reset, ratio_select;
  wire  half_rate_out_a, half_rate_out_a_n, half_rate_out_b, half_rate_out_b_n;
  wire  slow_rate_out_a, slow_rate_out_a_n, slow_rate_out_b, slow_rate_out_b_n;
  wire  phase_out, phase_out_n;
  int   err_total = 0;
  int   checks_done = 0;
  logic [2:0] held;
  clk_in_source src (.clk_sys(clk_sys), .clk_in(clk_in));
  clock_divider_two_four_six dut (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [2:0] seen, input logic [2:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Past the three-cycle detection delay of a rise
  task rise;
    @(posedge clk_in);
    repeat (5) @(negedge clk_sys);
  endtask
  task t_divide(input logic sel);
    int r;
    r = sel ? 6 : 4;
    @(negedge clk_sys);
    master_reset = 1'b1;
    enable_n = 1'b0;
    ratio_select = sel;
    repeat (10) @(negedge clk_sys);
    chk({half_rate_out_a, slow_rate_out_a, phase_out}, 3'h0);
    @(negedge clk_in);
    @(negedge clk_sys);
    master_reset = 1'b0;
    for (int k = 1; k <= 2 * r; k++)
    begin
      rise();
      chk({half_rate_out_a, slow_rate_out_a, phase_out},
          {k[0], k % r >= 1 && k % r <= r / 2, k % r == 1});
    end
    $display("divide test done");
  endtask
  task t_hold;
    @(posedge clk_in);
    @(negedge clk_sys);
    enable_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    held = {half_rate_out_a, slow_rate_out_a, phase_out};
    repeat (3) rise();
    chk({half_rate_out_a, slow_rate_out_a, phase_out}, {held[2:1], 1'b0});
    @(posedge clk_in);
    @(negedge clk_sys);
    enable_n = 1'b0;
    rise();
    chk({half_rate_out_a, 2'h0}, {~held[2], 2'h0});
    $display("hold test done");
  endtask
  initial
  begin
    resetn = 1'b0;
    enable_n = 1'b1;
    master_reset = 1'b0;
    ratio_select = 1'b0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    t_divide(1'b0);
    t_divide(1'b1);
    t_hold();
    end_of_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule
